/* hw/elpu_top.v */
// Encoder counters, speed, distance and limit blocking with APB registers
`timescale 1ns/1ps
`include "elpu_defs.vh"
// Function
// - Switches one/two block motor one fwd/rev
// - Switches three/four block motor two fwd/rev
// - Single channel: switches three/four block motor
// - One 32-bit quadrature counter per encoder
// - Counters hold full signed 32-bit range
// - Counters wrap to zero past extremes
// - Host reads and loads each counter
// - Counters start from zero after reset
// - Signed speed per encoder, within 127
// - Sample every time base plus one ticks
// - 32-bit destination held per channel
// - Distance is destination minus counter, divided
// - Distance saturates at minus/plus 127
// - Distance delivered as signed eight bits
// - Motor control selects position combinations
// - Local controls cannot select position modes
// - Limit switches share encoder channel lines
// - Detected switch halts that encoder, except switches one/two in single channel
module elpu_top #(
   parameter TICK_CYC = `ELPU_TICK_US * `ELPU_CLK_MHZ,
   parameter TICK_W = 16
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire enc1_a,
   input wire enc1_b,
   input wire enc2_a,
   input wire enc2_b,
   input wire limit_fwd_ch1,
   input wire limit_rev_ch1,
   input wire limit_fwd_ch2,
   input wire limit_rev_ch2,
   input wire [2:0] local_mode,
   input wire local_mode_set,
   output reg m1_fwd_block,
   output reg m1_rev_block,
   output reg m2_fwd_block,
   output reg m2_rev_block,
   output reg m1_pos_en,
   output reg m2_pos_en,
   output reg m1_closed_speed,
   output reg [7:0] dist1,
   output reg [7:0] dist2,
   output reg [7:0] speed1,
   output reg [7:0] speed2
);

   // Divider choice, 1 to 64 by powers of two, then 127
   function signed [32:0] elpu_div;
      input signed [32:0] d;
      input [2:0] s;
      begin
         case (s)
            3'h0: elpu_div = d;
            3'h1: elpu_div = d / 33'sd2;
            3'h2: elpu_div = d / 33'sd4;
            3'h3: elpu_div = d / 33'sd8;
            3'h4: elpu_div = d / 33'sd16;
            3'h5: elpu_div = d / 33'sd32;
            3'h6: elpu_div = d / 33'sd64;
            default: elpu_div = d / 33'sd127;
         endcase
      end
   endfunction

   // Clamp a signed 33-bit value to -127..+127
   function [7:0] elpu_sat;
      input signed [32:0] v;
      begin
         if (v > 33'sd127)
            elpu_sat = `ELPU_SPD_MAX;
         else if (v < -33'sd127)
            elpu_sat = `ELPU_SPD_MIN;
         else
            elpu_sat = v[7:0];
      end
   endfunction

   // Two-stage synchronisers for all encoder and limit pins
   reg [7:0] sync1;
   reg [7:0] sync2;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
      end else begin
         sync1 <= {limit_rev_ch2, limit_fwd_ch2, limit_rev_ch1, limit_fwd_ch1,
                   enc2_b, enc2_a, enc1_b, enc1_a};
         sync2 <= sync1;
      end
   end
   // Switch detects ride on the same lines as the encoder phases
   wire [3:0] det = sync2[7:4];
   wire [1:0] pha = {sync2[2], sync2[0]};
   wire [1:0] phb = {sync2[3], sync2[1]};

   // Settings
   reg single;
   reg [2:0] mode;
   reg [7:0] tbase;
   reg [2:0] divsel;
   reg [31:0] dest1;
   reg [31:0] dest2;
   reg local_refused;

   // APB decode; zero wait states, read data caught in setup
   wire setup = psel & ~penable;
   wire wr = psel & penable & pwrite;
   wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `ELPU_OFS_STATUS);
   wire wr_ok = wr & mapped;
   // No wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   wire [1:0] wr_cnt;
   assign wr_cnt[0] = wr_ok & (paddr == `ELPU_OFS_CNT1);
   assign wr_cnt[1] = wr_ok & (paddr == `ELPU_OFS_CNT2);

   // Per-channel counters and speed sampling
   wire [31:0] cnt [0:1];
   wire [7:0] spd [0:1];
   wire [1:0] halt;
   // Single channel keeps encoder one counting through its own lines
   assign halt[0] = ~single & (det[0] | det[1]);
   assign halt[1] = det[2] | det[3];

   // Shared time base: 256 us ticks, sample every tbase+1 ticks
   reg [TICK_W-1:0] tick_cnt;
   reg [7:0] tb_cnt;
   wire tick = (tick_cnt == TICK_CYC[TICK_W-1:0] - 1'b1);
   // Lowering tbase below the running count samples at the next tick
   wire sample = tick & (tb_cnt >= tbase);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= {TICK_W{1'b0}};
         tb_cnt <= 8'h00;
      end else begin
         tick_cnt <= tick ? {TICK_W{1'b0}} : tick_cnt + 1'b1;
         if (sample)
            tb_cnt <= 8'h00;
         else if (tick)
            tb_cnt <= tb_cnt + 1'b1;
      end
   end

   // Each channel gets its own copy of the decoder, counter and speed stage
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         reg a_q;
         reg b_q;
         reg [31:0] count;
         reg [31:0] last;
         reg [7:0] speed;
         // A single phase change counts unless the channel is halted; both at once is a glitch
         wire step = ((pha[g] ^ a_q) ^ (phb[g] ^ b_q)) & ~halt[g];
         wire up = a_q ^ phb[g];
         // Count change since the last sample, modulo 32 bits
         wire [31:0] delta = count - last;
         assign cnt[g] = count;
         assign spd[g] = speed;
         // Counter: host load wins over a count edge
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               a_q <= 1'b0;
               b_q <= 1'b0;
               count <= 32'h00000000;
               last <= 32'h00000000;
               speed <= 8'h00;
            end else begin
               a_q <= pha[g];
               b_q <= phb[g];
               if (wr_cnt[g])
                  count <= pwdata;
               else if (step & up)
                  count <= (count == 32'h7fffffff) ? 32'h00000000 : count + 1'b1;
               else if (step)
                  count <= (count == 32'h80000000) ? 32'h00000000 : count - 1'b1;
               // Delta over the period, clamped so a fast shaft cannot wrap
               if (sample) begin
                  last <= count;
                  speed <= elpu_sat({delta[31], delta});
               end
            end
         end
      end
   endgenerate

   // Distance per channel, 33 bits so the difference never overflows
   wire signed [32:0] diff1 = $signed({dest1[31], dest1}) - $signed({cnt[0][31], cnt[0]});
   wire signed [32:0] diff2 = $signed({dest2[31], dest2}) - $signed({cnt[1][31], cnt[1]});
   // Divide before clamping; truncation runs toward zero
   wire signed [32:0] q1 = elpu_div(diff1, divsel);
   wire signed [32:0] q2 = elpu_div(diff2, divsel);

   // Register writes; local panel may only pick speed modes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single <= 1'b0;
         mode <= `ELPU_MODE_OPEN;
         tbase <= `ELPU_RST_TBASE;
         divsel <= `ELPU_RST_DIVSEL;
         dest1 <= 32'h00000000;
         dest2 <= 32'h00000000;
         local_refused <= 1'b0;
      end else begin
         if (wr_ok && paddr == `ELPU_OFS_CTRL) begin
            single <= pwdata[`ELPU_CTRL_SINGLE];
            if (pwdata[`ELPU_CTRL_MODE_MSB:`ELPU_CTRL_MODE_LSB] <= `ELPU_MODE_POS_POS)
               mode <= pwdata[`ELPU_CTRL_MODE_MSB:`ELPU_CTRL_MODE_LSB];
         end else if (local_mode_set && local_mode <= `ELPU_MODE_CLOSED)
            mode <= local_mode;
         // Sticky flag: a refusal in the clear cycle still sticks
         if (local_mode_set && local_mode > `ELPU_MODE_CLOSED)
            local_refused <= 1'b1;
         else if (wr_ok && paddr == `ELPU_OFS_STATUS && pwdata[`ELPU_STAT_CLR])
            local_refused <= 1'b0;
         // Time base is not limited here; the host keeps it small
         if (wr_ok && paddr == `ELPU_OFS_TBASE)
            tbase <= pwdata[7:0];
         if (wr_ok && paddr == `ELPU_OFS_DIVSEL)
            divsel <= pwdata[2:0];
         if (wr_ok && paddr == `ELPU_OFS_DEST1)
            dest1 <= pwdata;
         if (wr_ok && paddr == `ELPU_OFS_DEST2)
            dest2 <= pwdata;
      end
   end

   // Registered outputs: blocking, mode decode, speed, distance
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m1_fwd_block <= 1'b0;
         m1_rev_block <= 1'b0;
         m2_fwd_block <= 1'b0;
         m2_rev_block <= 1'b0;
         m1_pos_en <= 1'b0;
         m2_pos_en <= 1'b0;
         m1_closed_speed <= 1'b0;
         dist1 <= 8'h00;
         dist2 <= 8'h00;
         speed1 <= 8'h00;
         speed2 <= 8'h00;
      end else begin
         // Single channel frees encoder one lines for a direct encoder
         m1_fwd_block <= single ? det[2] : det[0];
         m1_rev_block <= single ? det[3] : det[1];
         m2_fwd_block <= ~single & det[2];
         m2_rev_block <= ~single & det[3];
         // Mode decode; codes above four never reach mode
         m1_pos_en <= (mode == `ELPU_MODE_POS_POS);
         m2_pos_en <= (mode >= `ELPU_MODE_OPEN_POS);
         m1_closed_speed <= (mode == `ELPU_MODE_CLOSED) || (mode == `ELPU_MODE_CLOSED_POS);
         dist1 <= elpu_sat(q1);
         dist2 <= elpu_sat(q2);
         speed1 <= spd[0];
         speed2 <= spd[1];
      end
   end

   // Read mux, sampled in the setup cycle
   reg [31:0] rmux;
   always @* begin
      case (paddr)
         `ELPU_OFS_CTRL: rmux = {28'h0000000, mode, single};
         `ELPU_OFS_TBASE: rmux = {24'h000000, tbase};
         `ELPU_OFS_DIVSEL: rmux = {29'h00000000, divsel};
         `ELPU_OFS_CNT1: rmux = cnt[0];
         `ELPU_OFS_CNT2: rmux = cnt[1];
         `ELPU_OFS_DEST1: rmux = dest1;
         `ELPU_OFS_DEST2: rmux = dest2;
         `ELPU_OFS_SPEED: rmux = {16'h0000, spd[1], spd[0]};
         `ELPU_OFS_DIST: rmux = {16'h0000, dist2, dist1};
         `ELPU_OFS_STATUS: rmux = {25'h0000000, halt, local_refused, det};
         default: rmux = 32'h00000000;
      endcase
   end
   // Read data held through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (setup)
         prdata <= rmux;
   end

endmodule // elpu_top

/* common/elpu_defs.vh */
// Constants for the encoder, limit and position unit
`ifndef ELPU_DEFS_VH
`define ELPU_DEFS_VH
`define ELPU_CLK_MHZ 100
`define ELPU_TICK_US 256
`define ELPU_OFS_CTRL 8'h00
`define ELPU_OFS_TBASE 8'h04
`define ELPU_OFS_DIVSEL 8'h08
`define ELPU_OFS_CNT1 8'h0c
`define ELPU_OFS_CNT2 8'h10
`define ELPU_OFS_DEST1 8'h14
`define ELPU_OFS_DEST2 8'h18
`define ELPU_OFS_SPEED 8'h1c
`define ELPU_OFS_DIST 8'h20
`define ELPU_OFS_STATUS 8'h24
`define ELPU_CTRL_SINGLE 0
`define ELPU_CTRL_MODE_LSB 1
`define ELPU_CTRL_MODE_MSB 3
`define ELPU_STAT_CLR 4
`define ELPU_MODE_OPEN 3'h0
`define ELPU_MODE_CLOSED 3'h1
`define ELPU_MODE_OPEN_POS 3'h2
`define ELPU_MODE_CLOSED_POS 3'h3
`define ELPU_MODE_POS_POS 3'h4
`define ELPU_RST_TBASE 8'h04
`define ELPU_RST_DIVSEL 3'h0
`define ELPU_SPD_MAX 8'h7f
`define ELPU_SPD_MIN 8'h81
`endif

/* tb/elpu_top_properties.sv */
// Port checker for the encoder, limit and position unit
`timescale 1ns/1ps
module elpu_top_properties (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire limit_fwd_ch1,
   input wire limit_rev_ch1,
   input wire limit_fwd_ch2,
   input wire limit_rev_ch2,
   input wire m1_fwd_block,
   input wire m1_rev_block,
   input wire m2_fwd_block,
   input wire m2_rev_block,
   input wire m1_pos_en,
   input wire m2_pos_en,
   input wire m1_closed_speed,
   input wire [7:0] dist1,
   input wire [7:0] speed1
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase, and one aimed at no register
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_bad;
      s_acc ##0 (paddr > 8'h24 || paddr[1:0] != 2'h0);
   endsequence
   chk_ready_high: assert property (pready) else $error("pready low");
   chk_bad_err: assert property (s_bad |-> pslverr) else $error("no slverr");
   chk_err_acc: assert property (pslverr |-> psel && penable) else $error("slverr");
   // Read data may change only at a setup edge
   chk_rd_stands: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("prdata moved");
   // Pin to block output is two sync stages plus one register
   chk_m1_fwd: assert property (m1_fwd_block |-> $past(limit_fwd_ch1, 3)
      || $past(limit_fwd_ch2, 3)) else $error("m1 fwd block");
   chk_m1_rev: assert property (m1_rev_block |-> $past(limit_rev_ch1, 3)
      || $past(limit_rev_ch2, 3)) else $error("m1 rev block");
   chk_m2_fwd: assert property (m2_fwd_block |-> $past(limit_fwd_ch2, 3))
      else $error("m2 fwd block");
   chk_m2_rev: assert property (m2_rev_block |-> $past(limit_rev_ch2, 3))
      else $error("m2 rev block");
   chk_clamp_range: assert property (speed1 != 8'h80 && dist1 != 8'h80)
      else $error("value past 127");
   chk_mixed_modes: assert property (m1_pos_en |-> m2_pos_en && !m1_closed_speed)
      else $error("bad mode mix");
   // Position only ever follows a bus write, never the panel
   chk_local_pos: assert property ($rose(m2_pos_en) |-> $past(psel && penable && pwrite)
      || $past(psel && penable && pwrite, 2)) else $error("panel set position");
endmodule // elpu_top_properties
bind elpu_top elpu_top_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .limit_fwd_ch1(limit_fwd_ch1), .limit_rev_ch1(limit_rev_ch1),
   .limit_fwd_ch2(limit_fwd_ch2), .limit_rev_ch2(limit_rev_ch2),
   .m1_fwd_block(m1_fwd_block), .m1_rev_block(m1_rev_block), .m2_fwd_block(m2_fwd_block),
   .m2_rev_block(m2_rev_block), .m1_pos_en(m1_pos_en), .m2_pos_en(m2_pos_en),
   .m1_closed_speed(m1_closed_speed), .dist1(dist1), .speed1(speed1));

/* tb/elpu_enc_model.sv */
// Quadrature encoder sharing its two lines with limit switches
`timescale 1ns/1ps
module elpu_enc_model (
   input wire clk,
   input wire step,
   input wire dir,
   input wire [1:0] sw,
   output wire a,
   output wire b,
   output wire det_fwd,
   output wire det_rev
);
   reg [1:0] ph = 2'h0;
   // One gray step per request, up when dir is high
   always @(posedge clk) begin
      if (step) begin
         ph <= dir ? ph + 2'h1 : ph - 2'h1;
      end
   end
   // A closed switch grounds its line, hiding the phase
   assign a = ph[1] & ~sw[0];
   assign b = (ph[1] ^ ph[0]) & ~sw[1];
   assign det_fwd = sw[0];
   assign det_rev = sw[1];
endmodule // elpu_enc_model

/* tb/elpu_top_test.sv */
// Self-checking bench for the encoder, limit and position unit
`timescale 1ns/1ps
module elpu_top_test;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lset = 0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, seed = 32'h5a06c94c;
   reg [2:0] lmode = 3'h0;
   reg [1:0] stp = 2'h0, dir = 2'h0, sw1 = 2'h0, sw2 = 2'h0;
   reg [3:0] q;
   wire [31:0] prdata;
   wire pready, pslverr, e1a, e1b, e2a, e2b, l1f, l1r, l2f, l2r, m1f, m1r, m2f, m2r, m1p, m2p, m1c;
   wire [7:0] dist1, dist2, speed1, speed2;
   reg [31:0] expq[$];
   integer n_fail = 0, total_checks = 0, i, d, k;
   elpu_enc_model u_enc1 (.clk(pclk), .step(stp[0]), .dir(dir[0]), .sw(sw1), .a(e1a),
      .b(e1b), .det_fwd(l1f), .det_rev(l1r));
   elpu_enc_model u_enc2 (.clk(pclk), .step(stp[1]), .dir(dir[1]), .sw(sw2), .a(e2a),
      .b(e2b), .det_fwd(l2f), .det_rev(l2r));
   // Short tick keeps speed samples within a few cycles
   elpu_top #(.TICK_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enc1_a(e1a), .enc1_b(e1b), .enc2_a(e2a),
      .enc2_b(e2b), .limit_fwd_ch1(l1f), .limit_rev_ch1(l1r), .limit_fwd_ch2(l2f),
      .limit_rev_ch2(l2r), .local_mode(lmode), .local_mode_set(lset), .m1_fwd_block(m1f),
      .m1_rev_block(m1r), .m2_fwd_block(m2f), .m2_rev_block(m2r), .m1_pos_en(m1p),
      .m2_pos_en(m2p), .m1_closed_speed(m1c), .dist1(dist1), .dist2(dist2),
      .speed1(speed1), .speed2(speed2));
   initial begin
      forever #5 pclk = ~pclk;
   end
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      begin
         t = v ^ (v << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // Truncating divide then clamp to the signed byte
   function [7:0] dex(input integer v, input [2:0] s);
      integer r;
      begin
         r = v / (s == 3'h7 ? 127 : (1 << s));
         dex = r > 127 ? 8'h7f : (r < -127 ? 8'h81 : r[7:0]);
      end
   endfunction
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // Entered just after an edge; reads note their expectation first
   task apb(input w, input [7:0] a, input [31:0] dt);
      begin
         if (!w) expq.push_back(dt);
         psel <= 1;
         pwrite <= w;
         paddr <= a;
         pwdata <= dt;
         @(posedge pclk);
         penable <= 1;
         // pready is judged mid-cycle, once it has settled
         @(negedge pclk);
         while (pready !== 1'b1) begin
            @(posedge pclk);
            @(negedge pclk);
         end
         @(posedge pclk);
         psel <= 0;
         penable <= 0;
         @(posedge pclk);
      end
   endtask
   task steps(input integer ch, input integer n, input up);
      repeat (n) begin
         stp[ch] <= 1;
         dir[ch] <= up;
         @(posedge pclk);
         stp[ch] <= 0;
         @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask
   task wsp(input ch, input [7:0] e);
      begin
         for (k = 0; k < 20 && (ch ? speed2 : speed1) !== e; k = k + 1) @(posedge pclk);
         chk("spd", e, ch ? speed2 : speed1);
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // Read results are matched in issue order
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready) chk("rd", expq.pop_front(), prdata);
   end
   initial begin
      #200000;
      n_fail = n_fail + 1;
      wrap_up;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 8'h04, 32'h4);
      apb(0, 8'h0c, 32'h0);
      apb(0, 8'h2a, 32'h0);
      seed = xs(seed);
      apb(1, 8'h0c, seed);
      apb(0, 8'h0c, seed);
      apb(1, 8'h0c, 32'h7fffffff);
      steps(0, 1, 1);
      apb(0, 8'h0c, 32'h0);
      apb(1, 8'h0c, 32'h80000000);
      steps(0, 1, 0);
      apb(0, 8'h0c, 32'h0);
      steps(1, 6, 1);
      apb(0, 8'h10, 32'h6);
      steps(1, 10, 0);
      apb(0, 8'h10, 32'hfffffffc);
      // Forward switch grounds line A; B still moves and must not count
      sw2 <= 2'h1;
      steps(1, 2, 1);
      apb(0, 8'h10, 32'hfffffffc);
      apb(0, 8'h24, 32'h44);
      steps(1, 2, 0);
      apb(0, 8'h10, 32'hfffffffc);
      for (i = 0; i < 8; i = i + 1) begin
         if (i == 4) apb(1, 8'h00, 32'h1);
         sw1 <= {i[0], i[1]};
         sw2 <= {i[1], ~i[0]};
         repeat (5) @(posedge pclk);
         q = {i[1], i[0], ~i[0], i[1]};
         chk("blk", i > 3 ? {q[1:0], 2'h0} : q, {m1f, m1r, m2f, m2r});
      end
      sw1 <= 2'h0;
      sw2 <= 2'h0;
      for (i = 0; i < 5; i = i + 1) begin
         apb(1, 8'h00, i << 1);
         repeat (2) @(posedge pclk);
         chk("mode", (32'h6688 >> (3 * i)) & 32'h7, {m1p, m2p, m1c});
      end
      apb(1, 8'h00, 32'h0);
      // Panel asks for a position mode, then for closed loop speed
      lmode <= 3'h4;
      lset <= 1;
      @(posedge pclk);
      lmode <= 3'h1;
      @(posedge pclk);
      lset <= 0;
      repeat (2) @(posedge pclk);
      chk("local", 32'h1, {m1p, m2p, m1c});
      apb(0, 8'h24, 32'h10);
      apb(1, 8'h24, 32'h10);
      apb(0, 8'h24, 32'h0);
      apb(1, 8'h04, 32'h0);
      apb(1, 8'h0c, 32'h1000);
      wsp(0, 8'h7f);
      wsp(0, 8'h00);
      apb(1, 8'h0c, 32'h0);
      wsp(0, 8'h81);
      apb(1, 8'h10, 32'h30);
      wsp(1, 8'h34);
      // Counter two now holds 48, counter one zero
      for (i = 0; i < 8; i = i + 1) begin
         seed = xs(seed);
         d = $signed(seed[12:0]);
         apb(1, 8'h08, i);
         apb(1, 8'h14, d);
         apb(1, 8'h18, -d);
         repeat (2) @(posedge pclk);
         chk("dist", dex(d, i[2:0]), dist1);
         chk("dist2", dex(-d - 48, i[2:0]), dist2);
         apb(0, 8'h20, {dex(-d - 48, i[2:0]), dex(d, i[2:0])});
      end
      wrap_up;
   end
endmodule // elpu_top_test
